// >>> fsr_status_regs.sv
// Status and configuration registers of a serial flash with write protection, fed by the serial pins.
// What this block does
// - Busy bit set during program, erase or non-volatile status write; other commands except status read and suspend ignored.
// - Busy bit clears when the program, erase or status write completes.
// - Write enable command sets the write enable latch.
// - Latch clears at power-up and after disable, program, erase or status write.
// - Three-bit protect level is non-volatile, written by status write, default zero.
// - Direction bit selects counting from top (0) or bottom (1).
// - Granularity bit selects 4-kB sectors (1) or 64-kB blocks (0).
// - Complement bit inverts the chosen protected region.
// - Status protect 0 ignores protect pin; writes allowed whenever latch is set.
// - Status protect 1 with protect pin low locks all three status registers while quad is off.
// - Status protect 1 with protect pin high allows writes after write enable.
// - Busy, latch and suspend bits are never loaded from status write data.
// - Write enable then status write updates the non-volatile copies.
// - Volatile write enable then status write updates only volatile copies.
// - Lock bits exist only non-volatile; a volatile status write leaves them.
// - Suspend flag set by suspend while a program or erase runs, cleared by resume or power cycle.
// - Each lock bit can be set once on its own and then stays set.
// - Quad enable 0 keeps protect and pause/reset pins; 1 makes them data lines.
// - Shared pin is pause when select is 0, reset when 1, only without quad.
// - Drive field decodes 00 50%, 01 25%, 10 75%, 11 100%.
// - High frequency mode active while its bit is 1.
`timescale 1ns/10ps
`include "fsr_params.svh"
module fsr_status_regs #(
	parameter int unsigned STATUS_WRITE_CYCLES = 1000,
	parameter int unsigned PROGRAM_CYCLES = 2000,
	parameter int unsigned ERASE_CYCLES = 4000
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic spi_clk_pin,
	input wire logic chip_sel_n_pin,
	input wire logic data_in_pin,
	input wire logic data_line_two_pin,
	input wire logic data_line_three_pin,
	output logic data_out,
	output logic data_out_oe,
	output logic busy,
	output logic write_enable_latch,
	output logic suspend_flag,
	output logic [7:0] status_one,
	output logic [7:0] status_two,
	output logic [7:0] status_three,
	output logic [2:0] protect_level,
	output logic protect_direction,
	output logic protect_granularity,
	output logic protect_complement,
	output logic [2:0] secure_lock,
	output logic quad_lines_enable,
	output logic status_regs_locked,
	output logic hold_active,
	output logic pin_reset_active,
	output logic [6:0] drive_strength_pct,
	output logic high_freq_mode
);
	logic [4:0] pins_s;
	logic sclk_s, cs_n_s, di_s, wp_s, shared_s;
	logic sclk_prev_ff, cs_prev_ff;
	logic sclk_rise, sclk_fall, cs_rise;
	logic [2:0] bit_cnt_ff;
	logic [1:0] byte_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] opcode_ff, data1_ff, data2_ff;
	logic [7:0] nxt_byte;
	logic byte_done;
	logic reading_ff;
	logic [7:0] tx_ff;
	logic dout_ff;
	logic latch_ff, vol_armed_ff, susp_ff;
	fsr_pkg::fsr_op_e op_ff;
	logic [31:0] cnt_ff;
	fsr_pkg::fsr_cfg_s nv_ff;
	fsr_pkg::fsr_cfg_s vol_ff;
	logic [2:0] lock_ff;
	logic [1:0] drv_ff;
	logic is_read, is_wrsr, is_prog, is_erase;
	logic exec, acc, wr_s1, wr_s2, wr_s3;
	logic [7:0] s2_byte;
	logic wr_nv, wr_vol, pin_rst;

	fsr_sync #(.W(5), .RST_VAL(`FSR_PIN_RESET)) u_sync (
		.clk(core_clk),
		.rstn(rstn),
		.din({spi_clk_pin, chip_sel_n_pin, data_in_pin, data_line_two_pin, data_line_three_pin}),
		.dout(pins_s)
	);
	assign {sclk_s, cs_n_s, di_s, wp_s, shared_s} = pins_s;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sclk_prev_ff <= 1'b0;
			cs_prev_ff <= 1'b1;
		end else begin
			sclk_prev_ff <= sclk_s;
			cs_prev_ff <= cs_n_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_prev_ff;
	assign sclk_fall = ~sclk_s & sclk_prev_ff;
	assign cs_rise = cs_n_s & ~cs_prev_ff;

	// With quad lines on, both pin functions are off and the pins only carry data.
	assign status_regs_locked = vol_ff.status_protect & ~wp_s & ~vol_ff.quad_en;
	assign hold_active = ~vol_ff.quad_en & ~vol_ff.pin_select & ~shared_s & ~cs_n_s;
	assign pin_reset_active = ~vol_ff.quad_en & vol_ff.pin_select & ~shared_s;
	assign pin_rst = pin_reset_active;

	// Serial frame capture, mode 0: data sampled on rising clock edges.
	assign nxt_byte = {shift_ff[6:0], di_s};
	assign byte_done = ~cs_n_s & sclk_rise & ~hold_active & (bit_cnt_ff == 3'h7);

	always_ff @(posedge core_clk) begin
		if (!rstn || pin_rst || cs_n_s) begin
			bit_cnt_ff <= 3'h0;
			byte_cnt_ff <= 2'h0;
			shift_ff <= 8'h00;
		end else if (sclk_rise && !hold_active) begin
			shift_ff <= nxt_byte;
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			if (bit_cnt_ff == 3'h7 && byte_cnt_ff != 2'h3) begin
				byte_cnt_ff <= byte_cnt_ff + 2'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			opcode_ff <= 8'h00;
			data1_ff <= 8'h00;
			data2_ff <= 8'h00;
		end else if (byte_done) begin
			case (byte_cnt_ff)
				2'h0: opcode_ff <= nxt_byte;
				2'h1: data1_ff <= nxt_byte;
				2'h2: data2_ff <= nxt_byte;
				default: begin
				end
			endcase
		end
	end

	// Status read path; the register is reloaded each byte so polling sees live busy.
	always_ff @(posedge core_clk) begin
		if (!rstn || pin_rst || cs_n_s) begin
			reading_ff <= 1'b0;
			tx_ff <= 8'h00;
			dout_ff <= 1'b0;
		end else if (byte_done && (byte_cnt_ff == 2'h0 || reading_ff)) begin
			case (byte_cnt_ff == 2'h0 ? nxt_byte : opcode_ff)
				`FSR_OP_RDSR_ONE: begin
					reading_ff <= 1'b1;
					tx_ff <= status_one;
				end
				`FSR_OP_RDSR_TWO: begin
					reading_ff <= 1'b1;
					tx_ff <= status_two;
				end
				`FSR_OP_RDSR_THREE: begin
					reading_ff <= 1'b1;
					tx_ff <= status_three;
				end
				default: begin
					reading_ff <= 1'b0;
				end
			endcase
		end else if (sclk_fall && reading_ff && !hold_active) begin
			dout_ff <= tx_ff[7];
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end
	assign data_out = dout_ff;
	assign data_out_oe = reading_ff & ~cs_n_s & ~hold_active;

	// Commands act at the end of the frame and only on whole bytes.
	always_comb begin
		is_read = opcode_ff == `FSR_OP_RDSR_ONE || opcode_ff == `FSR_OP_RDSR_TWO || opcode_ff == `FSR_OP_RDSR_THREE;
		is_wrsr = opcode_ff == `FSR_OP_WRSR || opcode_ff == `FSR_OP_WRSR_TWO || opcode_ff == `FSR_OP_WRSR_THREE;
		is_prog = opcode_ff == `FSR_OP_PROG;
		is_erase = opcode_ff == `FSR_OP_ERASE_SECT || opcode_ff == `FSR_OP_ERASE_BLK || opcode_ff == `FSR_OP_ERASE_CHIP;
	end
	assign exec = cs_rise & (bit_cnt_ff == 3'h0) & (byte_cnt_ff != 2'h0) & ~pin_rst;
	// Suspend must reach a running operation, so it is the one command besides the status read taken while busy.
	assign acc = exec & ~is_read & (~busy | opcode_ff == `FSR_OP_SUSPEND);

	assign wr_s1 = opcode_ff == `FSR_OP_WRSR && byte_cnt_ff >= 2'h2;
	assign wr_s2 = (opcode_ff == `FSR_OP_WRSR && byte_cnt_ff == 2'h3) ||
		(opcode_ff == `FSR_OP_WRSR_TWO && byte_cnt_ff >= 2'h2);
	assign wr_s3 = opcode_ff == `FSR_OP_WRSR_THREE && byte_cnt_ff >= 2'h2;
	assign s2_byte = opcode_ff == `FSR_OP_WRSR ? data2_ff : data1_ff;
	assign wr_nv = acc & is_wrsr & latch_ff & ~status_regs_locked;
	assign wr_vol = acc & is_wrsr & ~latch_ff & vol_armed_ff & ~status_regs_locked;

	// Merge written bytes into a configuration copy; reserved positions are simply not read.
	function automatic fsr_pkg::fsr_cfg_s merge_cfg(input fsr_pkg::fsr_cfg_s c, input logic w1, input logic w2,
			input logic w3, input logic [7:0] b1, input logic [7:0] b2);
		fsr_pkg::fsr_cfg_s r;
		r = c;
		if (w1) begin
			r.level = b1[`FSR_S1_LEVEL_HI:`FSR_S1_LEVEL_LO];
			r.direction = b1[`FSR_S1_DIR];
			r.granularity = b1[`FSR_S1_GRAN];
			r.status_protect = b1[`FSR_S1_SRP];
		end
		if (w2) begin
			r.complement = b2[`FSR_S2_COMPL];
			r.quad_en = b2[`FSR_S2_QUAD];
		end
		if (w3) begin
			r.pin_select = b1[`FSR_S3_PINSEL];
			r.high_freq = b1[`FSR_S3_FAST];
		end
		return r;
	endfunction

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			nv_ff <= `FSR_CFG_RESET;
			vol_ff <= `FSR_CFG_RESET;
		end else if (wr_nv) begin
			nv_ff <= merge_cfg(nv_ff, wr_s1, wr_s2, wr_s3, data1_ff, s2_byte);
			vol_ff <= merge_cfg(vol_ff, wr_s1, wr_s2, wr_s3, data1_ff, s2_byte);
		end else if (wr_vol) begin
			vol_ff <= merge_cfg(vol_ff, wr_s1, wr_s2, wr_s3, data1_ff, s2_byte);
		end else if (pin_rst) begin
			vol_ff <= nv_ff;
		end
	end

	// Lock bits only ever gain ones, and only through the non-volatile path.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			lock_ff <= `FSR_LOCK_RESET;
		end else if (wr_nv && wr_s2) begin
			lock_ff <= lock_ff | s2_byte[`FSR_S2_LOCK_HI:`FSR_S2_LOCK_LO];
		end
	end

	// Drive strength has only a volatile copy, so either write path updates it.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			drv_ff <= `FSR_DRV_RESET;
		end else if ((wr_nv || wr_vol) && wr_s3) begin
			drv_ff <= data1_ff[`FSR_S3_DRV_HI:`FSR_S3_DRV_LO];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || pin_rst) begin
			latch_ff <= 1'b0;
		end else if (acc) begin
			if (opcode_ff == `FSR_OP_WREN) begin
				latch_ff <= 1'b1;
			end else if (opcode_ff == `FSR_OP_WRDI || is_wrsr || is_prog || is_erase) begin
				latch_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || pin_rst) begin
			vol_armed_ff <= 1'b0;
		end else if (acc) begin
			vol_armed_ff <= opcode_ff == `FSR_OP_WREN_VOL;
		end
	end

	// Operation timer; a suspended program or erase keeps its remaining count until a non-volatile status write reloads it.
	always_ff @(posedge core_clk) begin
		if (!rstn || pin_rst) begin
			op_ff <= fsr_pkg::OP_IDLE;
			cnt_ff <= 32'h0;
		end else if (acc && wr_nv) begin
			op_ff <= fsr_pkg::OP_STATUS;
			cnt_ff <= STATUS_WRITE_CYCLES;
		end else if (acc && latch_ff && is_prog && !susp_ff) begin
			op_ff <= fsr_pkg::OP_PROGRAM;
			cnt_ff <= PROGRAM_CYCLES;
		end else if (acc && latch_ff && is_erase && !susp_ff) begin
			op_ff <= fsr_pkg::OP_ERASE;
			cnt_ff <= ERASE_CYCLES;
		end else if (op_ff != fsr_pkg::OP_IDLE && !susp_ff) begin
			if (cnt_ff <= 32'h1) begin
				op_ff <= fsr_pkg::OP_IDLE;
				cnt_ff <= 32'h0;
			end else begin
				cnt_ff <= cnt_ff - 32'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || pin_rst) begin
			susp_ff <= 1'b0;
		end else if (acc && opcode_ff == `FSR_OP_SUSPEND &&
				(op_ff == fsr_pkg::OP_PROGRAM || op_ff == fsr_pkg::OP_ERASE)) begin
			susp_ff <= 1'b1;
		end else if (acc && opcode_ff == `FSR_OP_RESUME) begin
			susp_ff <= 1'b0;
		end
	end

	assign busy = (op_ff != fsr_pkg::OP_IDLE) & ~susp_ff;
	assign write_enable_latch = latch_ff;
	assign suspend_flag = susp_ff;
	// Volatile bits come from live state, never from write data. Reserved positions read zero.
	assign status_one = {vol_ff.status_protect, vol_ff.granularity, vol_ff.direction, vol_ff.level,
		latch_ff, busy};
	assign status_two = {susp_ff, vol_ff.complement, lock_ff, 1'b0, vol_ff.quad_en, 1'b0};
	assign status_three = {vol_ff.pin_select, drv_ff, vol_ff.high_freq, 4'h0};

	assign protect_level = vol_ff.level;
	assign protect_direction = vol_ff.direction;
	assign protect_granularity = vol_ff.granularity;
	assign protect_complement = vol_ff.complement;
	assign secure_lock = lock_ff;
	assign quad_lines_enable = vol_ff.quad_en;
	assign high_freq_mode = vol_ff.high_freq;

	always_comb begin
		case (drv_ff)
			2'h0: drive_strength_pct = `FSR_DRV_PCT_00;
			2'h1: drive_strength_pct = `FSR_DRV_PCT_01;
			2'h2: drive_strength_pct = `FSR_DRV_PCT_10;
			2'h3: drive_strength_pct = `FSR_DRV_PCT_11;
			default: drive_strength_pct = `FSR_DRV_PCT_00;
		endcase
	end
endmodule

// >>> fsr_params.svh
// Constants for the flash status register block: opcodes, bit positions, reset values.
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// Command opcodes. The write disable, program, erase and status read and write codes are plain defaults.
`define FSR_OP_WREN 8'h06
`define FSR_OP_WREN_VOL 8'h50
`define FSR_OP_WRSR 8'h01
`define FSR_OP_WRSR_TWO 8'h31
`define FSR_OP_WRSR_THREE 8'h11
`define FSR_OP_WRDI 8'h04
`define FSR_OP_RDSR_ONE 8'h05
`define FSR_OP_RDSR_TWO 8'h35
`define FSR_OP_RDSR_THREE 8'h15
`define FSR_OP_PROG 8'h02
`define FSR_OP_ERASE_SECT 8'h20
`define FSR_OP_ERASE_BLK 8'hd8
`define FSR_OP_ERASE_CHIP 8'hc7
`define FSR_OP_SUSPEND 8'h75
`define FSR_OP_RESUME 8'h7a

// Field positions in the first status register.
`define FSR_S1_BUSY 0
`define FSR_S1_LATCH 1
`define FSR_S1_LEVEL_LO 2
`define FSR_S1_LEVEL_HI 4
`define FSR_S1_DIR 5
`define FSR_S1_GRAN 6
`define FSR_S1_SRP 7

// Field positions in the second status register.
`define FSR_S2_QUAD 1
`define FSR_S2_LOCK_LO 3
`define FSR_S2_LOCK_HI 5
`define FSR_S2_COMPL 6
`define FSR_S2_SUSPEND 7

// Field positions in the third status register.
`define FSR_S3_FAST 4
`define FSR_S3_DRV_LO 5
`define FSR_S3_DRV_HI 6
`define FSR_S3_PINSEL 7

// Defaults after power-up.
`define FSR_CFG_RESET 10'h000
`define FSR_LOCK_RESET 3'h0
`define FSR_DRV_RESET 2'h0

// Output drive strength in percent per field code.
`define FSR_DRV_PCT_00 7'h32
`define FSR_DRV_PCT_01 7'h19
`define FSR_DRV_PCT_10 7'h4b
`define FSR_DRV_PCT_11 7'h64

// Pin synchroniser reset value: clock low, select high, data low, protect high, shared pin high.
`define FSR_PIN_RESET 5'h0b

`endif

// >>> fsr_pkg.sv
// Types shared by the flash status register block.
package fsr_pkg;

	typedef enum logic [1:0] {
		OP_IDLE,
		OP_STATUS,
		OP_PROGRAM,
		OP_ERASE
	} fsr_op_e;

	typedef struct packed {
		logic [2:0] level;
		logic direction;
		logic granularity;
		logic status_protect;
		logic complement;
		logic quad_en;
		logic pin_select;
		logic high_freq;
	} fsr_cfg_s;

endpackage

// >>> fsr_sync.sv
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/10ps
module fsr_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Each bit moves only when stages two and three agree, which filters single-cycle glitches.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dout <= RST_VAL;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					dout[i] <= s3_ff[i];
				end
			end
		end
	end
endmodule

// >>> fsr_status_regs_monitor.sv
// Concurrent checks on the ports of the flash status register block.
`timescale 1ns/10ps
module fsr_status_regs_monitor #(
	parameter int unsigned STATUS_WRITE_CYCLES = 1000,
	parameter int unsigned PROGRAM_CYCLES = 2000,
	parameter int unsigned ERASE_CYCLES = 4000
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic busy,
	input wire logic write_enable_latch,
	input wire logic suspend_flag,
	input wire logic [7:0] status_one,
	input wire logic [7:0] status_two,
	input wire logic [7:0] status_three,
	input wire logic [2:0] protect_level,
	input wire logic protect_direction,
	input wire logic protect_granularity,
	input wire logic protect_complement,
	input wire logic [2:0] secure_lock,
	input wire logic quad_lines_enable,
	input wire logic status_regs_locked,
	input wire logic hold_active,
	input wire logic pin_reset_active,
	input wire logic [6:0] drive_strength_pct,
	input wire logic high_freq_mode
);
	// A suspend restarts the count, so one bound covers every kind of operation.
	localparam int unsigned BUSY_MAX = STATUS_WRITE_CYCLES + PROGRAM_CYCLES + ERASE_CYCLES + 8;
	logic [15:0] busy_cnt_ff;

	always_ff @(posedge core_clk) begin
		if (!rstn || !busy) begin
			busy_cnt_ff <= 16'h0000;
		end else begin
			busy_cnt_ff <= busy_cnt_ff + 16'h0001;
		end
	end

	default clocking mon_cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	a_drive_decode: assert property (drive_strength_pct == (status_three[6:5] == 2'h0 ? 7'h32 :
		status_three[6:5] == 2'h1 ? 7'h19 : status_three[6:5] == 2'h2 ? 7'h4b : 7'h64))
		else $error("drive decode wrong");
	a_status_image: assert property (status_one[1:0] == {write_enable_latch, busy})
		else $error("busy or latch image wrong");
	a_region_image: assert property (status_one[6:2] ==
		{protect_granularity, protect_direction, protect_level} && status_two[6] == protect_complement)
		else $error("region field image wrong");
	a_reserved_zero: assert property (!(status_two[0] || status_two[2] || (|status_three[3:0])))
		else $error("reserved bit reads one");
	a_lock_sticky: assert property (secure_lock == status_two[5:3] &&
		!(|($past(secure_lock) & ~secure_lock))) else $error("lock bit cleared");
	a_no_latch_busy: assert property ($rose(write_enable_latch) |-> !$past(busy))
		else $error("latch set while busy");
	a_latch_cleared: assert property ($rose(busy) && !$past(suspend_flag) |-> !write_enable_latch)
		else $error("latch kept after write start");
	a_suspend_idle: assert property (suspend_flag |-> !busy && status_two[7])
		else $error("suspend flag wrong");
	a_quad_pins: assert property (quad_lines_enable |-> !(hold_active || pin_reset_active || status_regs_locked))
		else $error("pin function active in quad mode");
	a_pin_select: assert property (!(hold_active && status_three[7]) && !(pin_reset_active && !status_three[7]))
		else $error("shared pin function wrong");
	a_locked_src: assert property (status_regs_locked |-> status_one[7])
		else $error("locked without status protect");
	a_fast_mode_image: assert property (high_freq_mode == status_three[4])
		else $error("high frequency mode wrong");
	a_busy_bounded: assert property (int'(busy_cnt_ff) < BUSY_MAX)
		else $error("busy never ends");
	// Every write is refused while an operation runs, so no configuration field may move then.
	a_config_frozen: assert property (busy && $past(busy) |-> $stable(status_one[7:2]) &&
		$stable(status_two[6:1]) && $stable(status_three[7:4])) else $error("configuration changed while busy");

	c_busy: cover property ($rose(busy));
	c_suspend: cover property ($rose(suspend_flag));
	c_locked: cover property ($rose(status_regs_locked));
endmodule

bind fsr_status_regs fsr_status_regs_monitor #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES),
	.PROGRAM_CYCLES(PROGRAM_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_monitor (.core_clk, .rstn, .busy,
	.write_enable_latch, .suspend_flag, .status_one, .status_two, .status_three, .protect_level,
	.protect_direction, .protect_granularity, .protect_complement, .secure_lock, .quad_lines_enable,
	.status_regs_locked, .hold_active, .pin_reset_active, .drive_strength_pct, .high_freq_mode);

// >>> fsr_host_model.sv
// Serial host model that clocks whole-byte command frames into the flash status block.
`timescale 1ns/10ps
module fsr_host_model (
	input wire logic core_clk,
	input wire logic data_out,
	output logic spi_clk,
	output logic cs_n,
	output logic mosi
);
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// Half of the 80 ns serial period.
	task automatic half;
		repeat (10) @(negedge core_clk);
	endtask

	// The serial clock stands low outside frames; bits go MSB first, byte 1 is captured.
	task automatic xfer(input int n, input logic [23:0] tx, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		cs_n = 1'b0;
		half;
		for (i = 0; i < 8 * n; i++) begin
			mosi = tx[23 - i];
			half;
			spi_clk = 1'b1;
			if (i >= 8 && i < 16) begin
				rx = {rx[6:0], data_out};
			end
			half;
			spi_clk = 1'b0;
		end
		half;
		cs_n = 1'b1;
		// A released line must not look like a held bit.
		mosi = ~mosi;
		repeat (4) half;
	endtask
endmodule

// >>> fsr_status_regs_tb_top.sv
// Self-checking bench for the flash status register block.
`timescale 1ns/10ps
module fsr_status_regs_tb_top;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic data_line_two_pin = 1'b0;
	logic data_line_three_pin = 1'b1;
	logic spi_clk_pin, chip_sel_n_pin, data_in_pin, data_out, data_out_oe, busy, write_enable_latch, suspend_flag;
	logic protect_direction, protect_granularity, protect_complement, quad_lines_enable, status_regs_locked;
	logic hold_active, pin_reset_active, high_freq_mode;
	logic [7:0] status_one, status_two, status_three, rx;
	logic [2:0] protect_level, secure_lock;
	logic [6:0] drive_strength_pct;
	int fails = 0;
	int num_checks = 0;

	always #2 core_clk = ~core_clk;

	fsr_status_regs #(.STATUS_WRITE_CYCLES(400), .PROGRAM_CYCLES(600), .ERASE_CYCLES(800)) i_dut (
		.core_clk, .rstn, .spi_clk_pin, .chip_sel_n_pin, .data_in_pin, .data_line_two_pin, .data_line_three_pin,
		.data_out, .data_out_oe, .busy, .write_enable_latch, .suspend_flag, .status_one, .status_two, .status_three,
		.protect_level, .protect_direction, .protect_granularity, .protect_complement, .secure_lock,
		.quad_lines_enable, .status_regs_locked, .hold_active, .pin_reset_active, .drive_strength_pct, .high_freq_mode);
	fsr_host_model i_host (.core_clk, .data_out, .spi_clk(spi_clk_pin), .cs_n(chip_sel_n_pin), .mosi(data_in_pin));

	task cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task send(input int n, input logic [23:0] v);
		i_host.xfer(n, v, rx);
	endtask
	// Arm command, then a status write; 01h carries two data bytes, the others one.
	task wr(input logic [7:0] arm, input logic [7:0] op, input logic [15:0] d);
		send(1, {arm, 16'h0000});
		send((op == 8'h01) ? 3 : 2, {op, d});
	endtask
	task rd(input logic [7:0] op, input logic [7:0] exp);
		send(2, {op, 16'h0000});
		cmp({8'h00, rx}, {8'h00, exp});
	endtask
	task idle;
		int i;
		for (i = 0; i < 3000 && busy !== 1'b0; i++) begin
			@(negedge core_clk);
		end
		cmp(busy, 1'b0);
	endtask
	task shared_low;
		data_line_three_pin = 1'b0;
		repeat (10) @(negedge core_clk);
	endtask
	task tend(input string s);
		$display("test %s finished", s);
	endtask
	task test_done;
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#200000;
		fails++;
		test_done;
	end

	initial begin
		repeat (6) @(negedge core_clk);
		rstn = 1'b1;
		repeat (2) @(negedge core_clk);
		cmp({status_one, status_two}, 16'h0000);
		cmp({status_three, 1'b0, drive_strength_pct}, 16'h0032);
		tend("reset");
		send(1, 24'h060000);
		rd(8'h05, 8'h02);
		send(1, 24'h040000);
		cmp(write_enable_latch, 1'b0);
		tend("latch");
		wr(8'h06, 8'h01, 16'h7c4d);
		cmp({busy, write_enable_latch}, 2'b10);
		send(1, 24'h060000);
		cmp({busy, write_enable_latch}, 2'b10);
		idle;
		cmp(status_one, 8'h7c);
		rd(8'h35, 8'h48);
		tend("non-volatile write");
		wr(8'h06, 8'h11, 16'h8000);
		idle;
		wr(8'h50, 8'h01, 16'h0000);
		cmp({busy, secure_lock}, 4'h1);
		wr(8'h50, 8'h11, 16'hf000);
		rd(8'h15, 8'hf0);
		cmp({drive_strength_pct, high_freq_mode}, 8'hc9);
		shared_low;
		cmp(pin_reset_active, 1'b1);
		data_line_three_pin = 1'b1;
		repeat (10) @(negedge core_clk);
		cmp({high_freq_mode, status_one}, 9'h07c);
		tend("volatile write");
		wr(8'h06, 8'h01, 16'h8000);
		idle;
		cmp({status_regs_locked, secure_lock}, 4'h9);
		wr(8'h06, 8'h01, 16'h0000);
		cmp({busy, write_enable_latch, status_one}, 10'h080);
		data_line_two_pin = 1'b1;
		wr(8'h06, 8'h01, 16'h0000);
		idle;
		cmp({status_regs_locked, status_one}, 9'h000);
		tend("protect");
		send(1, 24'h060000);
		send(1, 24'h020000);
		cmp({busy, write_enable_latch}, 2'b10);
		send(1, 24'h750000);
		cmp({suspend_flag, busy}, 2'b10);
		send(1, 24'h7a0000);
		cmp({suspend_flag, busy}, 2'b01);
		idle;
		send(1, 24'h060000);
		send(1, 24'hd80000);
		cmp({busy, write_enable_latch}, 2'b10);
		idle;
		tend("suspend");
		// Both shared pins are driven by the bench, never tied to a rail.
		wr(8'h50, 8'h31, 16'h0200);
		cmp(quad_lines_enable, 1'b1);
		shared_low;
		cmp({pin_reset_active, hold_active}, 2'b00);
		data_line_three_pin = 1'b1;
		tend("quad");
		test_done;
	end
endmodule
